// file: test/cca_energy_link_quality_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cca_energy_link_quality_tb;
  logic       clk = 1'b0;             // System clock
  logic       rst_n = 1'b0;           // Reset, active low
  logic       cs_n, sck, mosi;        // Host pins
  logic       miso, oe_n, rx_en;      // Device outputs
  logic [7:0] signal_strength_indirect = 8'h00;           // Modem strength
  logic [7:0] corr = 8'h00;           // Modem correlator peak
  logic       sig = 1'b0, rdy = 1'b0; // Modem levels
  logic       pre = 1'b0, pend = 1'b0; // Modem pulses
  logic [7:0] rd, last_q;             // Read data, last quality
  int         errors = 0, check_count = 0; // Tallies
  always #10 clk = ~clk; // 50 MHz
  spi_host i_spi_host (.clk(clk), .miso(miso), .oe_n(oe_n),
    .cs_n(cs_n), .sck(sck), .mosi(mosi));
  // Short window keeps the run brief; it stays a multiple of 16
  cca_energy_link_quality #(.ED_CYC(160)) i_cca_energy_link_quality (
    .I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_SPI_CS_N(cs_n),
    .I_SPI_SCK(sck), .I_SPI_MOSI(mosi), .I_SIGNAL_STRENGTH_INDIRECT(signal_strength_indirect),
    .I_CORR_PEAK(corr), .I_SIG_DETECT(sig), .I_RX_READY(rdy),
    .I_PREAMBLE(pre), .I_PKT_END(pend), .O_RX_ENABLE(rx_en),
    .O_MISO(miso), .O_MISO_OE_N(oe_n));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_spi_host.xfer({1'b0, a, d, 8'h00}, 2, rd);
  endtask
  task automatic rdd(input logic [6:0] a);
    i_spi_host.xfer({1'b1, a, 16'h0000}, 2, rd);
  endtask
  task automatic wri(input logic [7:0] a, input logic [7:0] d);
    i_spi_host.xfer({1'b0, cca_pkg::OFS_IND_WIN, a, d}, 3, rd);
  endtask
  task automatic rdi(input logic [7:0] a);
    i_spi_host.xfer({1'b1, cca_pkg::OFS_IND_WIN, a, 8'h00}, 3, rd);
  endtask
  // Status polling is bounded; running out ends the run
  task automatic poll(input int b);
    for (int i = 0; i < 30; i++)
    begin
      rdd(cca_pkg::OFS_STATUS);
      if (rd[b] === 1'b1)
        return;
    end
    errors++;
    $display("BAD t=%0t seen=%h exp=1 poll timeout", $time, rd[b]);
    print_verdict();
  endtask
  task automatic run_cca(input logic [7:0] cfg, input logic [7:0] s,
                         input logic sd, input logic [7:0] res,
                         input logic [7:0] q);
    signal_strength_indirect = s;
    sig = sd;
    wr(cca_pkg::OFS_CONFIG, cfg);
    wr(cca_pkg::OFS_SEQCTL, cca_pkg::SEQ_CCA);
    check({7'h00, rx_en}, 8'h01);
    @(posedge clk) #1 rdy = 1'b1;
    poll(cca_pkg::BIT_CCA_DONE);
    check({7'h00, rx_en}, 8'h00);
    rdd(cca_pkg::OFS_RESULT);
    check(rd, res);
    rdd(cca_pkg::OFS_QUALITY);
    check(rd, q);
    last_q = q;
    rdd(cca_pkg::OFS_STATUS);
    check(rd, 8'h08);
    wr(cca_pkg::OFS_STATUS, 8'h08);
    rdd(cca_pkg::OFS_STATUS);
    check(rd, 8'h00);
    rdy = 1'b0;
  endtask
  task automatic t_reset();
    rdi(cca_pkg::IND_THRESH);
    check(rd, cca_pkg::RST_THRESH);
    rdi(cca_pkg::IND_OFFSET);
    check(rd, cca_pkg::RST_OFFSET);
    rdd(cca_pkg::OFS_STATUS);
    check(rd, 8'h00);
    rdd(7'h10); // Unmapped place reads zero
    check(rd, 8'h00);
    wr(cca_pkg::OFS_RESULT, 8'hff); // Read-only, write refused
    rdd(cca_pkg::OFS_RESULT);
    check(rd, 8'h00);
    rdd(cca_pkg::OFS_CONT);
    check(rd, 8'h00);
    signal_strength_indirect = 8'h5a;
    rdi(cca_pkg::IND_SIGNAL_STRENGTH_INDIRECT);
    check(rd, 8'h5a);
    $display("test reset done");
  endtask
  // Each entry: config, strength, signal present, expected result
  task automatic t_modes();
    logic [31:0] tbl [8] = '{32'h0060_0003, 32'h004b_0000,
      32'h0130_0104, 32'h0230_0105, 32'h0260_0002, 32'h0360_0003,
      32'h0760_0002, 32'h0760_0107};
    for (int i = 0; i < 8; i++)
      run_cca(tbl[i][31:24], tbl[i][23:16], tbl[i][8], tbl[i][7:0],
              tbl[i][23:16]);
    $display("test modes done");
  endtask
  task automatic t_offset();
    wri(cca_pkg::IND_OFFSET, 8'h10);
    run_cca(8'h00, 8'h40, 1'b0, 8'h03, 8'h50);
    wri(cca_pkg::IND_OFFSET, 8'hf0); // Negative, floors at zero
    run_cca(8'h00, 8'h08, 1'b0, 8'h00, 8'h00);
    wri(cca_pkg::IND_OFFSET, 8'h00);
    $display("test offset done");
  endtask
  // Start an assessment with the receiver not ready, then abort it
  task automatic t_abort();
    wr(cca_pkg::OFS_SEQCTL, cca_pkg::SEQ_CCA);
    check({7'h00, rx_en}, 8'h01);
    rdd(cca_pkg::OFS_STATUS); // Window must wait for the receiver
    check(rd, 8'h00);
    wr(cca_pkg::OFS_SEQCTL, cca_pkg::SEQ_IDLE);
    check({7'h00, rx_en}, 8'h00);
    rdd(cca_pkg::OFS_STATUS);
    check(rd, 8'h00);
    $display("test abort done");
  endtask
  task automatic t_rx();
    signal_strength_indirect = 8'h22;
    corr = 8'h44;
    wr(cca_pkg::OFS_CONFIG, 8'h08);
    wri(cca_pkg::IND_CCACTL, 8'h01);
    wr(cca_pkg::OFS_SEQCTL, cca_pkg::SEQ_RX);
    check({7'h00, rx_en}, 8'h01);
    @(posedge clk) #1 rdy = 1'b1;
    pre = 1'b1;
    @(posedge clk) #1 pre = 1'b0;
    rdd(cca_pkg::OFS_QUALITY); // Too early for the new value
    check(rd, last_q);
    repeat (3200) @(posedge clk);
    rdd(cca_pkg::OFS_QUALITY);
    check(rd, 8'h44);
    rdd(cca_pkg::OFS_CONT);
    check({7'h00, rd != 8'h00}, 8'h01);
    wri(cca_pkg::IND_CCACTL, 8'h00);
    rdd(cca_pkg::OFS_CONT);
    last_q = rd;
    signal_strength_indirect = 8'hc0; // Must not move a frozen value
    repeat (100) @(posedge clk);
    rdd(cca_pkg::OFS_CONT);
    check(rd, last_q);
    @(posedge clk) #1 pend = 1'b1;
    @(posedge clk) #1 pend = 1'b0;
    poll(cca_pkg::BIT_RX_DONE);
    wr(cca_pkg::OFS_STATUS, 8'h04);
    rdd(cca_pkg::OFS_STATUS);
    check(rd, 8'h00);
    rdy = 1'b0;
    $display("test receive done");
  endtask
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk);
    t_reset();
    t_modes();
    t_offset();
    t_abort();
    t_rx();
    print_verdict();
  end
endmodule // cca_energy_link_quality_tb
`default_nettype wire

// file: test/spi_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the register port: SPI mode 0, MSB first
module spi_host (
  input  wire logic clk,  // System clock
  input  wire logic miso, // Device data out
  input  wire logic oe_n, // Device drive enable, active low
  output var logic  cs_n, // Select, active low
  output var logic  sck,  // Serial clock, idles low
  output var logic  mosi  // Serial data to device
);
  logic line; // Level the host sees on the data line
  // A released line shows the inverse so a stale bit never matches
  assign line = oe_n ? ~miso : miso;
  // One frame of n bytes from tx top down; rd keeps the last byte
  // Each phase lasts five clocks to clear the device's two-flop sync
  task automatic xfer(input logic [23:0] tx, input int n,
                      output logic [7:0] rd);
    @(posedge clk) #1 cs_n = 1'b0;
    for (int i = 0; i < 8 * n; i++)
    begin
      mosi = tx[23 - i];
      repeat (5) @(posedge clk);
      #1 sck = 1'b1;
      rd = {rd[6:0], line}; // Sample on rising clock
      repeat (5) @(posedge clk);
      #1 sck = 1'b0;
    end
    repeat (5) @(posedge clk);
    #1 cs_n = 1'b1;
    repeat (5) @(posedge clk); // Deselect gap between frames
    #1; // Return off the edge so callers never race the design
  endtask
  // Idle levels from time zero
  initial
  begin
    cs_n = 1'b1;
    sck  = 1'b0;
    mosi = 1'b0;
  end
endmodule // spi_host
`default_nettype wire

// file: verilog/cca_energy_link_quality.sv
`timescale 1ns/1ps
`default_nettype none
module cca_energy_link_quality #(
  parameter int unsigned ED_CYC = cca_pkg::ED_CYCLES // Energy window cycles
) (
  input  wire logic       I_SYS_CLK,    // 50 MHz system clock
  input  wire logic       I_RESET_N,    // Asynchronous reset, active low
  input  wire logic       I_SPI_CS_N,   // SPI select pin, active low
  input  wire logic       I_SPI_SCK,    // SPI clock pin
  input  wire logic       I_SPI_MOSI,   // SPI data in pin
  input  wire logic [7:0] I_SIGNAL_STRENGTH_INDIRECT,       // Digital strength from modem
  input  wire logic [7:0] I_CORR_PEAK,  // Correlator peak from modem
  input  wire logic       I_SIG_DETECT, // Compliant signal present
  input  wire logic       I_RX_READY,   // Receiver warmed up
  input  wire logic       I_PREAMBLE,   // Pulse: preamble detected
  input  wire logic       I_PKT_END,    // Pulse: packet finished
  output logic            O_RX_ENABLE,  // Receiver power request
  output logic            O_MISO,       // SPI data out
  output logic            O_MISO_OE_N   // MISO enable, active low
);
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_WARM    = 3'b001,
    ST_ED      = 3'b010,
    ST_ED_DONE = 3'b011,
    ST_RX_WAIT = 3'b100,
    ST_RX_LQI  = 3'b101,
    ST_RX_PKT  = 3'b110
  } state_t;

  // Reset release and pin synchronisers
  logic [1:0] rst_sync_q;                        // Reset release chain
  logic       rst_n;                             // Synchronised reset
  logic [1:0] cs_s_q, sck_s_q, mosi_s_q;         // Two-flop pin chains
  logic       sck_prev_q;                        // Edge detect history
  // Registers
  state_t     state_q, state_d;                  // Sequencer
  logic [7:0] status_q, status_d;                // Completion flags
  logic [7:0] seqctl_q, seqctl_d;                // Sequence command
  logic [7:0] cfg_q, cfg_d;                      // Mode configuration
  logic [7:0] ccactl_q, ccactl_d;                // Indirect control
  logic [7:0] ofs_q, ofs_d;                      // Offset compensation
  logic [7:0] thr_q, thr_d;                      // Energy threshold
  logic [7:0] result_q, result_d;                // Final assessment
  logic [7:0] lqi_q, lqi_d;                      // Quality or energy
  logic [7:0] cont_q, cont_d;                    // Continuous strength
  logic [7:0] signal_strength_indirect_q, signal_strength_indirect_d;                    // Last strength sample
  logic       sig_q, sig_d;                      // Signal seen in window
  logic       rx_en_q, rx_en_d;                  // Receiver request
  // SPI shifter
  logic [2:0] bit_q, bit_d;                      // Bit within byte
  logic [1:0] byte_q, byte_d;                    // Byte within frame
  logic [7:0] rx_q, rx_d;                        // Incoming shift
  logic [7:0] cmd_q, cmd_d;                      // Command byte
  logic [7:0] iadr_q, iadr_d;                    // Indirect address
  logic [7:0] tx_q, tx_d;                        // Outgoing shift
  logic [7:0] hold_q, hold_d;                    // Next byte to send
  logic       load_q, load_d;                    // Hold pending
  logic       oe_n_q;                            // Registered enable
  // Helpers
  logic       sck_rise, sck_fall;                // Synced SCK edges
  logic [7:0] byte_v;                            // Completed byte
  logic [7:0] w1c;                               // Bits cleared by host
  logic       ed_start, ed_done, lq_start, lq_done;
  logic [7:0] ed_avg, lq_avg, lq_src;
  logic       en_hit, busy;
  logic [12:0] lqi_cyc_q, lqi_cyc_d;             // Cycles in quality window

  // Saturating signed offset add, shared by every reported reading except the indirect strength register
  function automatic logic [7:0] comp(input logic [7:0] v,
                                      input logic [7:0] o);
    logic signed [9:0] s;
    s = $signed({2'b00, v}) + $signed({{2{o[7]}}, o});
    if (s < 0)
      comp = 8'h00;
    else if (s > 10'sd255)
      comp = 8'hff;
    else
      comp = s[7:0];
  endfunction

  // Reset is released through two flops
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Averaging windows: energy and link quality delay
  signal_averager #(.DIV(ED_CYC >> cca_pkg::AVG_LOG2N),
                    .LOG2N(cca_pkg::AVG_LOG2N)) u_ed_avg (
    .clk   (I_SYS_CLK),
    .rst_n (rst_n),
    .start (ed_start),
    .data  (I_SIGNAL_STRENGTH_INDIRECT),
    .done  (ed_done),
    .avg   (ed_avg)
  );
  signal_averager #(.DIV(cca_pkg::LQI_CYCLES >> cca_pkg::AVG_LOG2N),
                    .LOG2N(cca_pkg::AVG_LOG2N)) u_lq_avg (
    .clk   (I_SYS_CLK),
    .rst_n (rst_n),
    .start (lq_start),
    .data  (lq_src),
    .done  (lq_done),
    .avg   (lq_avg)
  );

  assign sck_rise = sck_s_q[1] & ~sck_prev_q;
  assign sck_fall = ~sck_s_q[1] & sck_prev_q;
  assign byte_v   = {rx_q[6:0], mosi_s_q[1]};
  assign lq_src   = cfg_q[cca_pkg::BIT_LQI_SRC] ? I_CORR_PEAK : I_SIGNAL_STRENGTH_INDIRECT;
  assign en_hit   = comp(ed_avg, ofs_q) > thr_q;
  assign busy     = (state_q != ST_IDLE);

  // Next state for sequencer, registers and SPI shifter
  always_comb
  begin
    logic       wr_dir, wr_ind, e_flag, s_flag;
    logic [8:0] dif;
    wr_dir   = 1'b0;
    wr_ind   = 1'b0;
    e_flag   = 1'b0;
    s_flag   = 1'b0;
    dif      = 9'h000;
    w1c      = 8'h00;
    state_d  = state_q;
    status_d = status_q;
    seqctl_d = seqctl_q;
    cfg_d    = cfg_q;
    ccactl_d = ccactl_q;
    ofs_d    = ofs_q;
    thr_d    = thr_q;
    result_d = result_q;
    lqi_d    = lqi_q;
    cont_d   = cont_q;
    signal_strength_indirect_d   = I_SIGNAL_STRENGTH_INDIRECT; // Instantaneous strength, refreshed every cycle
    sig_d    = sig_q;
    rx_en_d  = rx_en_q;
    bit_d    = bit_q;
    byte_d   = byte_q;
    rx_d     = rx_q;
    cmd_d    = cmd_q;
    iadr_d   = iadr_q;
    tx_d     = tx_q;
    hold_d   = hold_q;
    load_d   = load_q;
    ed_start = 1'b0;
    lq_start = 1'b0;
    // SPI framing; deselect resets the frame counters
    if (cs_s_q[1])
    begin
      bit_d  = 3'd0;
      byte_d = 2'd0;
      load_d = 1'b0;
    end
    else if (sck_rise)
    begin
      rx_d  = byte_v;
      bit_d = bit_q + 3'd1;
      if (bit_q == 3'd7)
      begin
        if (byte_q != 2'd3)
          byte_d = byte_q + 2'd1;
        load_d = 1'b1;
        hold_d = 8'h00;
        if (byte_q == 2'd0)
        begin
          cmd_d = byte_v;
          // Direct read data is prepared for the next byte
          case (byte_v[6:0])
            cca_pkg::OFS_STATUS:  hold_d = status_q;
            cca_pkg::OFS_SEQCTL:  hold_d = seqctl_q;
            cca_pkg::OFS_CONFIG:  hold_d = cfg_q;
            cca_pkg::OFS_RESULT:  hold_d = result_q;
            cca_pkg::OFS_QUALITY: hold_d = lqi_q;
            cca_pkg::OFS_CONT:    hold_d = cont_q;
            default:              hold_d = 8'h00;
          endcase
        end
        else if (byte_q == 2'd1 && cmd_q[6:0] == cca_pkg::OFS_IND_WIN)
        begin
          iadr_d = byte_v;
          case (byte_v)
            cca_pkg::IND_CCACTL: hold_d = ccactl_q;
            cca_pkg::IND_OFFSET: hold_d = ofs_q;
            cca_pkg::IND_THRESH: hold_d = thr_q;
            cca_pkg::IND_SIGNAL_STRENGTH_INDIRECT:   hold_d = signal_strength_indirect_q;
            default:             hold_d = 8'h00;
          endcase
        end
        else if (byte_q == 2'd1)
          wr_dir = ~cmd_q[7];
        else if (byte_q == 2'd2 && cmd_q[6:0] == cca_pkg::OFS_IND_WIN)
          wr_ind = ~cmd_q[7];
      end
    end
    else if (sck_fall)
    begin
      // Reads are a side-effect free copy; flags never change here
      tx_d   = load_q ? hold_q : {tx_q[6:0], 1'b0};
      load_d = 1'b0;
    end
    // Register writes; read-only offsets ignore writes
    if (wr_dir)
    begin
      case (cmd_q[6:0])
        cca_pkg::OFS_STATUS: w1c = byte_v;
        cca_pkg::OFS_SEQCTL: seqctl_d = byte_v;
        cca_pkg::OFS_CONFIG: cfg_d = byte_v;
        default: ;
      endcase
    end
    if (wr_ind)
    begin
      case (iadr_q)
        cca_pkg::IND_CCACTL: ccactl_d = byte_v;
        cca_pkg::IND_OFFSET: ofs_d = byte_v;
        cca_pkg::IND_THRESH: thr_d = byte_v;
        default: ;
      endcase
    end
    // Only the completion bits are kept; writing one clears them
    status_d = status_q & ~w1c;
    // Sequencer
    case (state_q)
      ST_IDLE:
      begin
        rx_en_d = 1'b0;
        if (wr_dir && cmd_q[6:0] == cca_pkg::OFS_SEQCTL)
        begin
          if (byte_v == cca_pkg::SEQ_CCA)
          begin
            state_d = ST_WARM;
            rx_en_d = 1'b1;
          end
          else if (byte_v == cca_pkg::SEQ_RX)
          begin
            state_d = ST_RX_WAIT;
            rx_en_d = 1'b1;
          end
        end
      end
      ST_WARM:
        if (I_RX_READY)
        begin
          state_d  = ST_ED;
          ed_start = 1'b1;
          sig_d    = 1'b0;
        end
      ST_ED:
      begin
        sig_d = sig_q | I_SIG_DETECT;
        if (ed_done)
        begin
          // Compare only when the window has closed, latch first
          e_flag = en_hit;
          s_flag = sig_q | I_SIG_DETECT;
          case (cfg_q[1:0])
            cca_pkg::MODE_SIG: result_d[0] = s_flag;
            cca_pkg::MODE_CMB: result_d[0] = cfg_q[cca_pkg::BIT_AND_SEL] ?
                                 (e_flag & s_flag) : (e_flag | s_flag);
            default:           result_d[0] = e_flag;
          endcase
          result_d[1] = e_flag;
          result_d[2] = s_flag;
          lqi_d       = comp(ed_avg, ofs_q);
          state_d     = ST_ED_DONE;
        end
      end
      ST_ED_DONE:
      begin
        status_d[cca_pkg::BIT_CCA_DONE] = 1'b1;
        rx_en_d = 1'b0;
        state_d = ST_IDLE;
      end
      ST_RX_WAIT:
        if (I_PREAMBLE)
        begin
          state_d  = ST_RX_LQI;
          lq_start = 1'b1;
        end
      ST_RX_LQI:
        if (lq_done)
        begin
          lqi_d   = comp(lq_avg, ofs_q);
          state_d = ST_RX_PKT;
        end
      ST_RX_PKT:
        if (I_PKT_END)
        begin
          status_d[cca_pkg::BIT_RX_DONE] = 1'b1;
          rx_en_d = 1'b0;
          state_d = ST_IDLE;
        end
      default:
        state_d = ST_IDLE;
    endcase
    // Abort: writing idle command stops any sequence
    if (busy && wr_dir && cmd_q[6:0] == cca_pkg::OFS_SEQCTL &&
        byte_v == cca_pkg::SEQ_IDLE)
    begin
      state_d = ST_IDLE;
      rx_en_d = 1'b0;
    end
    // Running average over the packet, same scale as link quality
    if (ccactl_q[cca_pkg::BIT_CONT_EN] &&
        (state_q == ST_RX_LQI || state_q == ST_RX_PKT))
    begin
      dif    = 9'(comp(I_SIGNAL_STRENGTH_INDIRECT, ofs_q)) - 9'(cont_q);
      cont_d = cont_q + 8'($signed(dif) >>> cca_pkg::CONT_SHIFT);
    end
  end

  // Registers; only the synchroniser chains see raw pins
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_s_q  <= 2'b11;  sck_s_q  <= 2'b00;  mosi_s_q <= 2'b00;
      sck_prev_q <= 1'b0;
      state_q <= ST_IDLE;
      status_q <= cca_pkg::RST_ZERO;  seqctl_q <= cca_pkg::RST_ZERO;
      cfg_q    <= cca_pkg::RST_ZERO;  ccactl_q <= cca_pkg::RST_ZERO;
      ofs_q    <= cca_pkg::RST_OFFSET; thr_q   <= cca_pkg::RST_THRESH;
      result_q <= cca_pkg::RST_ZERO;  lqi_q    <= cca_pkg::RST_ZERO;
      cont_q   <= cca_pkg::RST_ZERO;  signal_strength_indirect_q   <= cca_pkg::RST_ZERO;
      sig_q <= 1'b0;  rx_en_q <= 1'b0;
      bit_q <= 3'd0;  byte_q  <= 2'd0;  rx_q <= 8'h00;  cmd_q <= 8'h00;
      iadr_q <= 8'h00;  tx_q <= 8'h00;  hold_q <= 8'h00;  load_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else
    begin
      cs_s_q   <= {cs_s_q[0], I_SPI_CS_N};
      sck_s_q  <= {sck_s_q[0], I_SPI_SCK};
      mosi_s_q <= {mosi_s_q[0], I_SPI_MOSI};
      sck_prev_q <= sck_s_q[1];
      state_q <= state_d;
      status_q <= status_d;  seqctl_q <= seqctl_d;  cfg_q <= cfg_d;
      ccactl_q <= ccactl_d;  ofs_q <= ofs_d;  thr_q <= thr_d;
      result_q <= result_d;  lqi_q <= lqi_d;  cont_q <= cont_d;
      signal_strength_indirect_q <= signal_strength_indirect_d;  sig_q <= sig_d;  rx_en_q <= rx_en_d;
      bit_q <= bit_d;  byte_q <= byte_d;  rx_q <= rx_d;  cmd_q <= cmd_d;
      iadr_q <= iadr_d;  tx_q <= tx_d;  hold_q <= hold_d;  load_q <= load_d;
      oe_n_q <= cs_s_q[1];
    end
  end

  assign O_RX_ENABLE = rx_en_q;
  assign O_MISO      = tx_q[7];
  assign O_MISO_OE_N = oe_n_q;

  // Checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!rst_n);
  sequence s_window_close;
    state_q == ST_ED && ed_done;
  endsequence
  sequence s_flag_after;
    state_q == ST_ED_DONE ##1 status_q[cca_pkg::BIT_CCA_DONE];
  endsequence
  a_flag_after_latch: assert property (s_window_close |=> s_flag_after)
    else $error("completion flag not raised after latched result");
  a_cca_flag_cause: assert property ($rose(status_q[cca_pkg::BIT_CCA_DONE])
    |-> $past(state_q) == ST_ED_DONE)
    else $error("assessment flag set without completion");
  a_flag_only_w1c: assert property ($fell(status_q[cca_pkg::BIT_CCA_DONE])
    |-> $past(w1c[cca_pkg::BIT_CCA_DONE]))
    else $error("completion flag cleared without write one");
  a_ed_rx_on: assert property (state_q == ST_ED |-> rx_en_q)
    else $error("energy window without receiver on");
  a_combined_mode: assert property (s_window_close
    ##0 (cfg_q[1:0] == cca_pkg::MODE_CMB) |=> result_q[0] ==
    (cfg_q[cca_pkg::BIT_AND_SEL] ? (result_q[1] & result_q[2])
                                 : (result_q[1] | result_q[2])))
    else $error("combined result wrong");
  a_signal_mode: assert property (s_window_close
    ##0 (cfg_q[1:0] == cca_pkg::MODE_SIG) |=> result_q[0] == result_q[2])
    else $error("signal mode result wrong");
  a_energy_mode: assert property (s_window_close
    ##0 (cfg_q[1:0] == cca_pkg::MODE_ED) |=> result_q[0] == result_q[1])
    else $error("energy mode result wrong");
  // Counts cycles spent in the quality window; at 8191 it goes back to zero instead of holding.
  // A counter is used because a delay range this long would be unrolled.
  always_comb
  begin
    lqi_cyc_d = 13'h0000;
    if (state_q == ST_RX_LQI && lqi_cyc_q != 13'h1fff)
      lqi_cyc_d = lqi_cyc_q + 13'h0001;
  end

  // Window counter register
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      lqi_cyc_q <= 13'h0000;
    else
      lqi_cyc_q <= lqi_cyc_d;
  end
  a_lqi_delay: assert property (state_q == ST_RX_LQI && lq_done
    |-> lqi_cyc_q == 13'(cca_pkg::LQI_CYCLES))
    else $error("quality window length wrong");
  a_lqi_not_late: assert property (state_q == ST_RX_LQI
    |-> lqi_cyc_q <= 13'(cca_pkg::LQI_CYCLES))
    else $error("quality window overran");
  a_rx_done_flag: assert property (state_q == ST_RX_PKT && I_PKT_END
    |=> status_q[cca_pkg::BIT_RX_DONE])
    else $error("receive completion flag missing");
  a_cont_frozen: assert property (!ccactl_q[cca_pkg::BIT_CONT_EN]
    |=> $stable(cont_q))
    else $error("continuous value moved while disabled");
endmodule // cca_energy_link_quality
`default_nettype wire

// file: verilog/cca_pkg.sv
// Behaviour
// - Energy mode flags energy above threshold
// - Enable receiver before energy averaging
// - Signal mode flags compliant signal presence
// - Combined mode uses programmable AND or OR
// - Energy averaged over fixed 128 us window
// - Config bit picks strength or correlator source
// - Link quality final 64 us after preamble
// - Continuous strength tracks packet when enabled
// - Assessment completion sets status bit three
// - Receive start one; completion sets bit two
// - Result, quality, strength at fixed offsets
// - Continuous value valid only when enabled
// - Programmable offset added to reported readings; the indirect strength register reads raw
// - Completion bits cleared only by writing one
`default_nettype none
package cca_pkg;
  // Direct register offsets
  localparam logic [6:0] OFS_STATUS  = 7'h00;
  localparam logic [6:0] OFS_SEQCTL  = 7'h03;
  localparam logic [6:0] OFS_CONFIG  = 7'h07;
  localparam logic [6:0] OFS_RESULT  = 7'h0b;
  localparam logic [6:0] OFS_QUALITY = 7'h25;
  localparam logic [6:0] OFS_CONT    = 7'h26;
  localparam logic [6:0] OFS_IND_WIN = 7'h3f; // Gateway to indirect space
  // Indirect register offsets
  localparam logic [7:0] IND_CCACTL  = 8'h25;
  localparam logic [7:0] IND_OFFSET  = 8'h26;
  localparam logic [7:0] IND_THRESH  = 8'h27;
  localparam logic [7:0] IND_SIGNAL_STRENGTH_INDIRECT    = 8'h5b;
  // Field positions
  localparam int unsigned BIT_RX_DONE  = 2;
  localparam int unsigned BIT_CCA_DONE = 3;
  localparam int unsigned BIT_AND_SEL  = 2; // Config: 1 = AND, 0 = OR
  localparam int unsigned BIT_LQI_SRC  = 3; // Config: 1 = correlator
  localparam int unsigned BIT_CONT_EN  = 0; // Control: continuous enable
  // Sequence commands and assessment modes
  localparam logic [7:0] SEQ_IDLE = 8'h00;
  localparam logic [7:0] SEQ_RX   = 8'h01;
  localparam logic [7:0] SEQ_CCA  = 8'h03;
  localparam logic [1:0] MODE_ED  = 2'h0;
  localparam logic [1:0] MODE_EN  = 2'h1;
  localparam logic [1:0] MODE_SIG = 2'h2;
  localparam logic [1:0] MODE_CMB = 2'h3;
  // Reset values
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [7:0] RST_THRESH = 8'h4b;
  // Timing
  localparam int unsigned CLK_MHZ      = 50;
  localparam int unsigned ED_WINDOW_US = 128;
  localparam int unsigned LQI_DELAY_US = 64;
  localparam int unsigned ED_CYCLES    = ED_WINDOW_US * CLK_MHZ;
  localparam int unsigned LQI_CYCLES   = LQI_DELAY_US * CLK_MHZ;
  localparam int unsigned AVG_LOG2N    = 4; // Sixteen samples per window
  localparam int unsigned CONT_SHIFT   = 3; // Running average weight
endpackage
`default_nettype wire

// file: verilog/signal_averager.sv
`timescale 1ns/1ps
`default_nettype none
// Takes 2**LOG2N evenly spaced samples over a window and returns the mean
module signal_averager #(
  parameter int unsigned DIV   = 400, // Cycles between samples
  parameter int unsigned LOG2N = 4    // Log2 of sample count
) (
  input  wire logic       clk,   // System clock
  input  wire logic       rst_n, // Synchronised reset, active low
  input  wire logic       start, // Pulse: clear and begin a window
  input  wire logic [7:0] data,  // Sample source
  output logic            done,  // Pulse: window complete
  output logic [7:0]      avg    // Mean of the window
);
  logic [31:0]      div_q, div_d;   // Sample spacing divider
  logic [LOG2N:0]   cnt_q, cnt_d;   // Samples taken
  logic [LOG2N+7:0] sum_q, sum_d;   // Running sum
  logic             run_q, run_d;   // Window open
  logic             done_d;

  // Divider pulse paces the samples so the window length is exact
  always_comb
  begin
    div_d  = div_q;
    cnt_d  = cnt_q;
    sum_d  = sum_q;
    run_d  = run_q;
    done_d = 1'b0;
    if (start)
    begin
      div_d = 32'(DIV - 1);
      cnt_d = '0;
      sum_d = '0;
      run_d = 1'b1;
    end
    else if (run_q)
    begin
      if (div_q == 32'd0)
      begin
        // Take one sample, then re-arm or close
        div_d = 32'(DIV - 1);
        sum_d = sum_q + (LOG2N+8)'(data);
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == (LOG2N+1)'((1 << LOG2N) - 1))
        begin
          run_d  = 1'b0;
          done_d = 1'b1;
        end
      end
      else
        div_d = div_q - 32'd1;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q <= '0;
      cnt_q <= '0;
      sum_q <= '0;
      run_q <= 1'b0;
      done  <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      cnt_q <= cnt_d;
      sum_q <= sum_d;
      run_q <= run_d;
      done  <= done_d;
    end
  end

  // Mean is the top eight bits of the sum; valid with and after done
  assign avg = sum_q[LOG2N+7:LOG2N];
endmodule // signal_averager
`default_nettype wire
